/* File: hw/gtv_granter.sv */
`timescale 1ns/100ps
// Voucher granter: member allocation, grant counters, voucher to ticket
module gtv_granter (
   input  wire logic                                ref_clk,
   input  wire logic                                reset,
   input  wire gtv_pkg::gtv_add_s                   card_add,
   input  wire logic [gtv_pkg::SLOT_W-1:0]          query_slot,
   output logic      [gtv_pkg::MEMBER_W-1:0]        query_member,
   output logic      [gtv_pkg::MEMBER_W-1:0]        assigned_member,
   output logic                                     assigned_valid,
   input  wire logic                                own_is_lan,
   input  wire logic [gtv_pkg::MEMBER_W-1:0]        own_member,
   input  wire logic [gtv_pkg::CNT_W-1:0]           capacity,
   input  wire logic                                pkt_in_valid,
   input  wire gtv_pkg::gtv_packet_s                pkt_in,
   output logic                                     pkt_out_valid,
   output gtv_pkg::gtv_packet_s                     pkt_out,
   output logic                                     granted,
   output logic      [gtv_pkg::NUM_BUS*gtv_pkg::CNT_W-1:0] grant_count
);
   // Member allocation state per type
   logic [31:0] used_sccp_r, used_sccp_nxt;
   logic [31:0] used_lan_r,  used_lan_nxt;
   logic [5:0]  n_sccp_r,    n_sccp_nxt;
   logic [5:0]  n_lan_r,     n_lan_nxt;
   logic [4:0]  asg_r,       asg_nxt;
   logic        asg_v_r,     asg_v_nxt;
   logic [4:0]  new_member;

   function automatic logic [4:0] lowest_free(input logic [31:0] used);
      logic [4:0] m;
      m = gtv_pkg::MEMBER_MAX;
      for (int i = 31; i >= 0; i--) begin
         if (!used[i]) begin
            m = 5'(i);
         end
      end
      return m;
   endfunction : lowest_free

   always_comb begin
      used_sccp_nxt = used_sccp_r;
      used_lan_nxt  = used_lan_r;
      n_sccp_nxt    = n_sccp_r;
      n_lan_nxt     = n_lan_r;
      asg_v_nxt     = 1'b0;
      new_member    = gtv_pkg::MEMBER_MAX;
      // Separate pools, so both groups may hold the same member value
      if (card_add.valid && card_add.is_lan) begin //RULE4
         if (n_lan_r >= gtv_pkg::LAN_LIMIT) begin //RULE5
            new_member = gtv_pkg::MEMBER_MAX;
         end else begin
            new_member = lowest_free(used_lan_r); //RULE3
         end
         used_lan_nxt[new_member] = 1'b1;
         if (n_lan_r != 6'h3f) begin
            n_lan_nxt = n_lan_r + 6'h01;
         end
         asg_v_nxt = 1'b1;
      end else if (card_add.valid) begin
         if (n_sccp_r >= gtv_pkg::SCCP_LIMIT) begin //RULE5
            new_member = gtv_pkg::MEMBER_MAX;
         end else begin
            new_member = lowest_free(used_sccp_r); //RULE3
         end
         used_sccp_nxt[new_member] = 1'b1;
         if (n_sccp_r != 6'h3f) begin
            n_sccp_nxt = n_sccp_r + 6'h01;
         end
         asg_v_nxt = 1'b1;
      end
      asg_nxt = asg_v_nxt ? new_member : asg_r; //RULE2
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         used_sccp_r <= '0;
         used_lan_r  <= '0;
         n_sccp_r    <= '0;
         n_lan_r     <= '0;
         asg_r       <= '0;
         asg_v_r     <= 1'b0;
      end else begin
         used_sccp_r <= used_sccp_nxt;
         used_lan_r  <= used_lan_nxt;
         n_sccp_r    <= n_sccp_nxt;
         n_lan_r     <= n_lan_nxt;
         asg_r       <= asg_nxt;
         asg_v_r     <= asg_v_nxt;
      end
   end

   assign assigned_member = asg_r;
   assign assigned_valid  = asg_v_r;

   gtv_member_table u_table (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .wr_en     (card_add.valid),
      .wr_slot   (card_add.slot),
      .wr_member (new_member),
      .rd_slot   (query_slot),
      .rd_member (query_member)
   );

   // Grant counters, one per bus, and packet path
   logic [gtv_pkg::CNT_W-1:0]    cnt_r [gtv_pkg::NUM_BUS];
   logic [gtv_pkg::CNT_W-1:0]    cnt_nxt [gtv_pkg::NUM_BUS];
   logic [gtv_pkg::RELOAD_W-1:0] tmr_r, tmr_nxt;
   gtv_pkg::gtv_packet_s         pkt_r, pkt_nxt;
   logic                         pv_r, pv_nxt;
   logic                         gr_r, gr_nxt;
   logic                         reload;
   logic                         has_cap;
   logic [4:0]                   own_group;

   always_comb begin
      own_group = own_is_lan ? gtv_pkg::GRP_LAN_COPY : gtv_pkg::GRP_SCCP; //RULE1
      reload    = (tmr_r == gtv_pkg::RELOAD_W'(gtv_pkg::RELOAD_CYC - 1));
      tmr_nxt   = reload ? '0 : tmr_r + 1'b1;
      // Capacity only while every bus counter is nonzero
      has_cap = 1'b1;
      for (int b = 0; b < gtv_pkg::NUM_BUS; b++) begin
         if (cnt_r[b] == '0) begin
            has_cap = 1'b0; //RULE9
         end
      end
      pkt_nxt = pkt_in;
      pv_nxt  = pkt_in_valid;
      gr_nxt  = 1'b0;
      for (int b = 0; b < gtv_pkg::NUM_BUS; b++) begin
         cnt_nxt[b] = cnt_r[b];
      end
      if (pkt_in_valid && pkt_in.kind == gtv_pkg::GTV_VOUCHER &&
          pkt_in.group == own_group && has_cap) begin //RULE7
         pkt_nxt.kind  = gtv_pkg::GTV_TICKET; //RULE8
         pkt_nxt.group = own_member; //RULE8
         gr_nxt        = 1'b1;
         for (int b = 0; b < gtv_pkg::NUM_BUS; b++) begin
            // Guard kept although has_cap already blocks a grant at zero
            if (cnt_r[b] != '0) begin
               cnt_nxt[b] = cnt_r[b] - 1'b1; //RULE18
            end
         end
      end
      // Reload takes priority; a grant in the same cycle is absorbed by the fresh value
      if (reload) begin
         for (int b = 0; b < gtv_pkg::NUM_BUS; b++) begin
            cnt_nxt[b] = capacity; //RULE10
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         for (int b = 0; b < gtv_pkg::NUM_BUS; b++) begin
            cnt_r[b] <= '0;
         end
         tmr_r <= '0;
         pkt_r <= '0;
         pv_r  <= 1'b0;
         gr_r  <= 1'b0;
      end else begin
         for (int b = 0; b < gtv_pkg::NUM_BUS; b++) begin
            cnt_r[b] <= cnt_nxt[b];
         end
         tmr_r <= tmr_nxt;
         pkt_r <= pkt_nxt;
         pv_r  <= pv_nxt;
         gr_r  <= gr_nxt;
      end
   end

   always_comb begin
      for (int b = 0; b < gtv_pkg::NUM_BUS; b++) begin
         grant_count[b*gtv_pkg::CNT_W +: gtv_pkg::CNT_W] = cnt_r[b];
      end
   end

   assign pkt_out       = pkt_r;
   assign pkt_out_valid = pv_r;
   assign granted       = gr_r;

   a_grant_ticket: assert property (@(posedge ref_clk) disable iff (reset) //RULE8
      granted |-> pkt_out_valid && pkt_out.kind == gtv_pkg::GTV_TICKET
                  && pkt_out.group == $past(own_member))
      else $error("grant without ticket carrying member");
   a_pass_unchanged: assert property (@(posedge ref_clk) disable iff (reset) //RULE7
      pkt_in_valid && !(pkt_in.kind == gtv_pkg::GTV_VOUCHER && pkt_in.group == own_group
      && has_cap) |=> pkt_out_valid && pkt_out == $past(pkt_in) && !granted)
      else $error("packet altered without grant");
   a_no_grant_zero: assert property (@(posedge ref_clk) disable iff (reset) //RULE9
      cnt_r[0] == '0 |=> !granted)
      else $error("grant from empty counter");
   a_no_grant_bus1: assert property (@(posedge ref_clk) disable iff (reset) //RULE9
      cnt_r[1] == '0 |=> !granted)
      else $error("grant from empty second counter");
   a_cnt_decrement: assert property (@(posedge ref_clk) disable iff (reset) //RULE18
      gr_nxt && !reload |=> cnt_r[0] == $past(cnt_r[0]) - 1'b1)
      else $error("counter not decremented by one");
   a_cnt_floor: assert property (@(posedge ref_clk) disable iff (reset) //RULE18
      cnt_r[1] == '0 && !reload |=> cnt_r[1] == '0)
      else $error("counter wrapped below zero");
   a_cnt_reload: assert property (@(posedge ref_clk) disable iff (reset) //RULE10
      reload |=> cnt_r[1] == $past(capacity))
      else $error("counter not reloaded");
   a_group_match: assert property (@(posedge ref_clk) disable iff (reset) //RULE1
      granted |-> $past(pkt_in_valid) && $past(pkt_in.group) == $past(own_group))
      else $error("grant for a foreign group");
   a_member_range: assert property (@(posedge ref_clk) disable iff (reset) //RULE5
      card_add.valid && !card_add.is_lan && n_sccp_r >= gtv_pkg::SCCP_LIMIT
      |=> assigned_valid && assigned_member == gtv_pkg::MEMBER_MAX)
      else $error("overflow card not given member 31");
   a_lan_overflow: assert property (@(posedge ref_clk) disable iff (reset) //RULE5
      card_add.valid && card_add.is_lan && n_lan_r >= gtv_pkg::LAN_LIMIT
      |=> assigned_valid && assigned_member == gtv_pkg::MEMBER_MAX)
      else $error("overflow lan card not given member 31");
   a_member_lowest: assert property (@(posedge ref_clk) disable iff (reset) //RULE3
      card_add.valid && card_add.is_lan && n_lan_r == '0 && used_lan_r == '0
      |=> assigned_member == 5'h00)
      else $error("first card not member 0");
   a_member_indep: assert property (@(posedge ref_clk) disable iff (reset) //RULE4
      card_add.valid && card_add.is_lan |=> used_sccp_r == $past(used_sccp_r))
      else $error("lan card altered sccp pool");
endmodule : gtv_granter

/* File: shared/gtv_pkg.sv */
// Package of constants and types for the group voucher granter
// Contract
// [RULE1] Voucher group is 1 for network management, 2 for LAN copy, 3 for SCCP.
// [RULE2] Every granter member number lies in 0 through 31.
// [RULE3] A new granter takes the lowest member number free among its type.
// [RULE4] LAN-copy and SCCP member numbers are allocated independently.
// [RULE5] Beyond 25 translation or 30 LAN-copy granters, new cards get member 31.
// [RULE6] Link card issues a voucher with the group matching its message class.
// [RULE7] Vouchers pass unchanged by granters without capacity.
// [RULE8] Accepting granter makes a ticket, writes its member, decrements every bus counter. A grant in a reload cycle leaves the counters at capacity instead.
// [RULE9] A granter whose counter reached zero stops granting.
// [RULE10] Granters periodically reload per-bus counters from available capacity.
// [RULE11] Requester maps saved group and returned member to the bus address.
// [RULE12] Link cards discard sequenced class 1 SCCP traffic from high-speed links.
// [RULE13] Class 0 SCCP for the node is discarded when the SCCP queue is full.
// [RULE14] SCCP messages queued longer than 2 seconds are discarded.
// [RULE15] LAN-copy messages are discarded on full queue or after 2 seconds.
// [RULE16] Discards increment the lost-SCCP or LAN-copy discard counters.
// [RULE17] Voucher handling applies only to SCCP for the node's own point codes.
// [RULE18] A counter never drops below zero; at zero the voucher passes on.
package gtv_pkg;
   localparam int         NUM_BUS       = 2;
   localparam int         CNT_W         = 8;
   localparam int         MEMBER_W      = 5;
   localparam int         SLOT_W        = 5;
   localparam int         NUM_SLOT      = 32;
   localparam logic [4:0] GRP_NETMGMT   = 5'h01;
   localparam logic [4:0] GRP_LAN_COPY  = 5'h02;
   localparam logic [4:0] GRP_SCCP      = 5'h03;
   localparam logic [4:0] MEMBER_MAX    = 5'h1f;
   localparam logic [5:0] SCCP_LIMIT    = 6'h19;
   localparam logic [5:0] LAN_LIMIT     = 6'h1e;
   localparam int         RELOAD_US     = 100;
   localparam int         CLK_MHZ       = 25;
   localparam int         RELOAD_CYC    = RELOAD_US * CLK_MHZ;
   localparam int         RELOAD_W      = 12;

   typedef enum logic {GTV_VOUCHER, GTV_TICKET} gtv_kind_e;

   typedef struct packed {
      gtv_kind_e  kind;
      logic [4:0] group;
      logic [7:0] source;
   } gtv_packet_s;

   typedef struct packed {
      logic       valid;
      logic       is_lan;
      logic [4:0] slot;
   } gtv_add_s;
endpackage : gtv_pkg

/* File: hw/gtv_member_table.sv */
`timescale 1ns/100ps
// Member number table: one registered entry per card slot
module gtv_member_table (
   input  wire logic                           ref_clk,
   input  wire logic                           reset,
   input  wire logic                           wr_en,
   input  wire logic [gtv_pkg::SLOT_W-1:0]     wr_slot,
   input  wire logic [gtv_pkg::MEMBER_W-1:0]   wr_member,
   input  wire logic [gtv_pkg::SLOT_W-1:0]     rd_slot,
   output logic      [gtv_pkg::MEMBER_W-1:0]   rd_member
);
   logic [gtv_pkg::MEMBER_W-1:0] mem_r [gtv_pkg::NUM_SLOT];
   logic [gtv_pkg::MEMBER_W-1:0] rd_member_nxt;

   always_comb begin
      rd_member_nxt = mem_r[rd_slot];
   end

   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem_r[wr_slot] <= wr_member;
      end
      if (reset) begin
         rd_member <= '0;
      end else begin
         rd_member <= rd_member_nxt;
      end
   end
endmodule : gtv_member_table

/* File: test/gtv_link_model.sv */
// Link card model: voucher queue, discards, ticket to bus address mapping
`timescale 1ns/100ps
module gtv_link_model #(
   parameter int AGE_CYC = 50000000
) (
   input  wire logic                 ref_clk,
   input  wire logic                 reset,
   input  wire logic                 fire,
   input  wire logic [1:0]           msg_class,
   input  wire logic                 as_ticket,
   input  wire logic                 sequenced,
   input  wire logic                 own_dest,
   input  wire logic                 hold,
   input  wire logic                 ret_valid,
   input  wire gtv_pkg::gtv_packet_s ret_pkt,
   output logic                      pkt_in_valid,
   output gtv_pkg::gtv_packet_s      pkt_in,
   output logic [7:0]                bus_addr,
   output logic [7:0]                lost_sccp_counter,
   output logic [7:0]                lan_copy_discard_counter
);
   // Default age limit is two seconds of ref_clk; one queue slot only
   gtv_pkg::gtv_packet_s req, q_pkt_r, q_pkt_nxt;
   logic                 q_v_r, q_v_nxt;
   logic [31:0]          age_r, age_nxt;
   logic [4:0]           grp_r, grp_nxt;
   logic [7:0]           lost_r, lost_nxt;
   logic [7:0]           lan_r, lan_nxt;
   logic [7:0]           addr_r, addr_nxt;
   logic                 is_sccp, take, issue_q, aged, drop_new;

   // Address plan of this model: group in the top bits, member below
   function automatic logic [7:0] bus_address(input logic [4:0] grp, input logic [4:0] mbr);
      return {grp[2:0], mbr};
   endfunction : bus_address

   always_comb begin
      req.kind = as_ticket ? gtv_pkg::GTV_TICKET : gtv_pkg::GTV_VOUCHER;
      req.group = (msg_class == 2'h0) ? gtv_pkg::GRP_NETMGMT :
                  (msg_class == 2'h1) ? gtv_pkg::GRP_LAN_COPY : gtv_pkg::GRP_SCCP;
      req.source = 8'h5a;
      is_sccp  = (msg_class == 2'h2);
      // SCCP is spread by vouchers only when node-addressed and unsequenced; the other classes always are
      take     = fire && !(is_sccp && (!own_dest || sequenced));
      issue_q  = q_v_r && !hold;
      aged     = q_v_r && hold && (age_r == 32'(AGE_CYC - 1));
      drop_new = take && q_v_r;
      pkt_in_valid = issue_q || (take && !q_v_r && !hold);
      // Idle bus never repeats the last packet, so a stale sample cannot pass
      pkt_in = issue_q ? q_pkt_r : fire ? req : gtv_pkg::gtv_packet_s'(~req);
      q_v_nxt   = q_v_r;
      q_pkt_nxt = q_pkt_r;
      age_nxt   = age_r + 32'h1;
      if (issue_q || aged) begin
         q_v_nxt = 1'b0;
      end
      if (take && !q_v_r && hold) begin
         q_v_nxt   = 1'b1;
         q_pkt_nxt = req;
         age_nxt   = '0;
      end
      lost_nxt = lost_r;
      lan_nxt  = lan_r;
      if (fire && is_sccp && own_dest && sequenced) begin
         lost_nxt = lost_nxt + 8'h01;
      end
      if (drop_new && is_sccp) begin
         lost_nxt = lost_nxt + 8'h01;
      end
      if (drop_new && msg_class == 2'h1) begin
         lan_nxt = lan_nxt + 8'h01;
      end
      if (aged && q_pkt_r.group == gtv_pkg::GRP_SCCP) begin
         lost_nxt = lost_nxt + 8'h01;
      end
      if (aged && q_pkt_r.group == gtv_pkg::GRP_LAN_COPY) begin
         lan_nxt = lan_nxt + 8'h01;
      end
      // Saved group pairs with the member that the returning ticket carries
      grp_nxt  = pkt_in_valid ? pkt_in.group : grp_r;
      addr_nxt = addr_r;
      if (ret_valid && ret_pkt.kind == gtv_pkg::GTV_TICKET) begin
         addr_nxt = bus_address(grp_r, ret_pkt.group);
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         q_v_r   <= 1'b0;
         q_pkt_r <= '0;
         age_r   <= '0;
         grp_r   <= '0;
         lost_r  <= '0;
         lan_r   <= '0;
         addr_r  <= '0;
      end else begin
         q_v_r   <= q_v_nxt;
         q_pkt_r <= q_pkt_nxt;
         age_r   <= age_nxt;
         grp_r   <= grp_nxt;
         lost_r  <= lost_nxt;
         lan_r   <= lan_nxt;
         addr_r  <= addr_nxt;
      end
   end

   assign bus_addr                 = addr_r;
   assign lost_sccp_counter        = lost_r;
   assign lan_copy_discard_counter = lan_r;
endmodule : gtv_link_model

/* File: test/tb_top.sv */
// Testbench for the voucher granter
`timescale 1ns/100ps
module tb_top;
   logic                 ref_clk = 1'b0;
   logic                 reset = 1'b1;
   gtv_pkg::gtv_add_s    card_add = '0;
   logic [4:0]           query_slot = 5'h00;
   logic [4:0]           own_member = 5'h07;
   logic [4:0]           query_member, assigned_member;
   logic                 assigned_valid, pkt_in_valid, pkt_out_valid, granted;
   logic                 own_is_lan = 1'b0;
   logic [7:0]           capacity = 8'h03;
   logic                 fire = 1'b0;
   logic                 as_ticket = 1'b0;
   logic [1:0]           msg_class = 2'h2;
   logic                 sequenced = 1'b0;
   logic                 own_dest = 1'b1;
   logic                 hold = 1'b0;
   logic [7:0]           bus_addr, lost_sccp_counter, lan_copy_discard_counter;
   gtv_pkg::gtv_packet_s pkt_in, pkt_out;
   logic [15:0]          grant_count;
   logic [4:0]           grp [3] = '{gtv_pkg::GRP_NETMGMT, gtv_pkg::GRP_LAN_COPY, gtv_pkg::GRP_SCCP};
   int                   bad_count = 0;
   int                   compares = 0;
   int                   cyc = 0;

   always #20 ref_clk = ~ref_clk;

   gtv_granter u_dut (.ref_clk, .reset, .card_add, .query_slot, .query_member,
      .assigned_member, .assigned_valid, .own_is_lan, .own_member, .capacity,
      .pkt_in_valid, .pkt_in, .pkt_out_valid, .pkt_out, .granted, .grant_count);
   // Ageing limit shortened so the queue scenario stays brief
   gtv_link_model #(.AGE_CYC(8)) u_link (.ref_clk, .reset, .fire, .msg_class, .as_ticket,
      .sequenced, .own_dest, .hold, .ret_valid(pkt_out_valid), .ret_pkt(pkt_out),
      .pkt_in_valid, .pkt_in, .bus_addr, .lost_sccp_counter, .lan_copy_discard_counter);

   task automatic close_out;
      $display("Checks %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic chk_pkt(input gtv_pkg::gtv_packet_s got, input gtv_pkg::gtv_packet_s exp);
      chk({2'h0, got}, {2'h0, exp}, "packet out");
   endtask : chk_pkt

   task automatic add_card(input logic lan, input logic [4:0] slot, input logic [4:0] exp);
      card_add = '{valid: 1'b1, is_lan: lan, slot: slot};
      @(negedge ref_clk);
      card_add.valid = 1'b0;
      query_slot = slot;
      chk(assigned_valid, 1'b1, "assigned pulse");
      chk(assigned_member, exp, "assigned member");
      @(negedge ref_clk);
      chk(assigned_valid, 1'b0, "assigned pulse end");
      chk(query_member, exp, "stored member");
   endtask : add_card

   task automatic send(input logic [1:0] cls, input logic tkt, input logic exp_g,
                       input logic [15:0] exp_cnt);
      gtv_pkg::gtv_packet_s exp;
      exp.kind = gtv_pkg::gtv_kind_e'(tkt | exp_g);
      exp.group = exp_g ? own_member : grp[cls];
      exp.source = 8'h5a;
      msg_class = cls;
      as_ticket = tkt;
      fire = 1'b1;
      @(negedge ref_clk);
      fire = 1'b0;
      chk(pkt_out_valid, 1'b1, "packet valid");
      chk_pkt(pkt_out, exp);
      chk(granted, exp_g, "granted");
      chk(grant_count, exp_cnt, "grant counters");
      @(negedge ref_clk);
      chk(pkt_out_valid, 1'b0, "packet valid end");
      if (exp_g) begin
         chk(bus_addr, {8'h00, grp[cls][2:0], own_member}, "bus address");
      end
   endtask : send

   task automatic offer(input logic [1:0] cls);
      msg_class = cls;
      fire = 1'b1;
      @(negedge ref_clk);
      fire = 1'b0;
   endtask : offer

   task automatic test_discard;
      own_dest = 1'b0;
      offer(2'h2);
      chk(pkt_out_valid, 1'b0, "foreign sccp");
      own_dest = 1'b1;
      sequenced = 1'b1;
      offer(2'h2);
      chk(pkt_out_valid, 1'b0, "sequenced sccp");
      sequenced = 1'b0;
      hold = 1'b1;
      offer(2'h2);
      offer(2'h1);
      chk(pkt_out_valid, 1'b0, "held voucher");
      offer(2'h2);
      repeat (8) @(negedge ref_clk);
      chk(lost_sccp_counter, 8'h03, "lost sccp");
      chk(lan_copy_discard_counter, 8'h01, "lan discards");
      offer(2'h1);
      hold = 1'b0;
      @(negedge ref_clk);
      chk(pkt_out_valid, 1'b1, "queued voucher");
      chk(pkt_out.group, gtv_pkg::GRP_LAN_COPY, "queued group");
      chk(lan_copy_discard_counter, 8'h01, "lan discards kept");
   endtask : test_discard

   task automatic wait_reload;
      for (int i = 0; i < 3000 && grant_count === 16'h0000; i++) @(negedge ref_clk);
   endtask : wait_reload

   task automatic test_members;
      for (int i = 0; i < 26; i++) add_card(1'b0, 5'(i), (i < 25) ? 5'(i) : 5'h1f);
      for (int i = 0; i < 31; i++) add_card(1'b1, 5'(i), (i < 30) ? 5'(i) : 5'h1f);
      add_card(1'b0, 5'h1f, 5'h1f);
   endtask : test_members

   task automatic test_grants;
      send(2'h2, 1'b0, 1'b0, 16'h0000);
      wait_reload();
      chk(grant_count, 16'h0303, "reload value");
      send(2'h0, 1'b0, 1'b0, 16'h0303);
      send(2'h1, 1'b0, 1'b0, 16'h0303);
      send(2'h2, 1'b1, 1'b0, 16'h0303);
      send(2'h2, 1'b0, 1'b1, 16'h0202);
      send(2'h2, 1'b0, 1'b1, 16'h0101);
      send(2'h2, 1'b0, 1'b1, 16'h0000);
      send(2'h2, 1'b0, 1'b0, 16'h0000);
   endtask : test_grants

   task automatic test_lan;
      own_is_lan = 1'b1;
      own_member = 5'h1c;
      capacity = 8'h01;
      wait_reload();
      chk(grant_count, 16'h0101, "reload value");
      send(2'h2, 1'b0, 1'b0, 16'h0101);
      send(2'h1, 1'b0, 1'b1, 16'h0000);
      send(2'h1, 1'b0, 1'b0, 16'h0000);
   endtask : test_lan

   // Two reload periods plus setup need about 5020 cycles; the ceiling leaves slack
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         bad_count++;
         close_out();
      end
   end

   initial begin
      repeat (16) @(negedge ref_clk);
      reset = 1'b0;
      @(negedge ref_clk);
      test_members();
      test_discard();
      test_grants();
      test_lan();
      close_out();
   end
endmodule : tb_top
